// ---- hw/hci_top.sv ----
// Functional notes
// - Bus-style strap low selects strobe-plus-direction, high selects separate read and write strobes.
// - The port answers only while the active-low select is held low.
// - In serial mode each input bit is captured on a rising shift-clock edge.
// - Serial output bits launch on rising edges when edge select is low, falling when high.
// - Strobe-plus-direction style samples the data bus as write data when strobe active, direction 0.
// - Strobe-plus-direction style drives read data when strobe active and direction 1.
// - In separate-strobe style the addressed register is driven while the read strobe is low and the write strobe high.
// - Port-style strap high selects the parallel port, low the serial port.
// - In separate-strobe style a low write strobe starts a write and the bus is sampled as data.
`include "hci_params.svh"

module hci_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Straps
  input wire logic port_style_select,
  input wire logic bus_style_select,
  input wire logic output_edge_select,
  // Control pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic data_strobe_n,
  input wire logic [`HCI_ADDR_W-1:0] addr,
  // Data bus
  input wire logic [`HCI_DATA_W-1:0] d_in,
  output logic [`HCI_DATA_W-1:0] d_out,
  output logic d_oe,
  // Serial output
  output logic serial_out,
  output logic serial_oe,
  // Register bank side
  output logic reg_rd,
  output logic reg_wr,
  output logic [`HCI_ADDR_W-1:0] reg_addr,
  output logic [`HCI_DATA_W-1:0] reg_wdata,
  input wire logic [`HCI_DATA_W-1:0] reg_rd_data
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  hci_pkg::hci_pins_t pins_raw;
  hci_pkg::hci_pins_t pins;
  logic [`HCI_PIN_W-1:0] pins_sync;

  // All pins share one delay, so data and strobes stay aligned
  assign pins_raw = '{
    cs_n: cs_n,
    sclk: sclk,
    serial_in: serial_in,
    data_strobe_n: data_strobe_n,
    output_edge_select: output_edge_select,
    bus_style_select: bus_style_select,
    port_style_select: port_style_select,
    d_in: d_in,
    addr: addr
  };

  hci_sync #(
    .WIDTH(`HCI_PIN_W),
    .RST_VAL(`HCI_PIN_RST)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign pins = pins_sync;

  // ----------------------------------------
  // State
  // ----------------------------------------
  hci_pkg::hci_state_t st;
  hci_pkg::hci_state_t next_st;

  logic sclk_rise;
  logic sclk_fall;
  logic launch_edge;
  logic wr_act;
  logic rd_act;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.req.rd = 1'b0;
    next_st.req.wr = 1'b0;
    next_st.sclk_q = pins.sclk;
    sclk_rise = pins.sclk & ~st.sclk_q;
    sclk_fall = ~pins.sclk & st.sclk_q;
    launch_edge = pins.output_edge_select ? sclk_fall : sclk_rise;
    // Shared pins: direction or write strobe, data strobe or read strobe
    if (pins.bus_style_select)
    begin
      wr_act = ~pins.serial_in;
      rd_act = ~pins.data_strobe_n & pins.serial_in;
    end
    else
    begin
      wr_act = ~pins.data_strobe_n & ~pins.serial_in;
      rd_act = ~pins.data_strobe_n & pins.serial_in;
    end

    if (pins.cs_n)
    begin
      // A deselect aborts any open access; a new frame needs a fresh select
      next_st.par_phase = hci_pkg::HCI_PAR_IDLE;
      next_st.bit_cnt = '0;
      next_st.load_pending = 1'b0;
      next_st.d_oe = 1'b0;
      next_st.serial_oe = 1'b0;
    end
    else if (pins.port_style_select)
    begin
      next_st.serial_oe = 1'b0;
      next_st.bit_cnt = '0;
      unique case (st.par_phase)
        hci_pkg::HCI_PAR_IDLE:
        begin
          next_st.d_oe = 1'b0;
          if (wr_act)
          begin
            next_st.par_phase = hci_pkg::HCI_PAR_WRITE;
            next_st.req.addr = pins.addr;
            next_st.req.wdata = pins.d_in;
          end
          else if (rd_act)
          begin
            next_st.par_phase = hci_pkg::HCI_PAR_READ;
            next_st.req.addr = pins.addr;
            next_st.req.rd = 1'b1;
          end
        end
        hci_pkg::HCI_PAR_WRITE:
        begin
          // Data is held from the last cycle the strobe was seen active
          if (wr_act)
          begin
            next_st.req.addr = pins.addr;
            next_st.req.wdata = pins.d_in;
          end
          else
          begin
            next_st.req.wr = 1'b1;
            next_st.par_phase = hci_pkg::HCI_PAR_IDLE;
          end
        end
        hci_pkg::HCI_PAR_READ:
        begin
          if (rd_act)
          begin
            next_st.d_oe = 1'b1;
            next_st.d_out = reg_rd_data;
          end
          else
          begin
            next_st.d_oe = 1'b0;
            next_st.par_phase = hci_pkg::HCI_PAR_IDLE;
          end
        end
        default:
        begin
          next_st.par_phase = hci_pkg::HCI_PAR_IDLE;
        end
      endcase
    end
    else
    begin
      next_st.par_phase = hci_pkg::HCI_PAR_IDLE;
      next_st.d_oe = 1'b0;
      if (st.load_pending)
      begin
        next_st.sout = reg_rd_data;
        next_st.load_pending = 1'b0;
      end
      if (sclk_rise && st.bit_cnt < `HCI_SER_FRAME_BITS)
      begin
        next_st.bit_cnt = st.bit_cnt + 5'h01;
        if (st.bit_cnt < `HCI_SER_CMD_BITS)
        begin
          next_st.cmd = {pins.serial_in, st.cmd[`HCI_DATA_W-1:1]};
        end
        else
        begin
          next_st.sdata = {pins.serial_in, st.sdata[`HCI_DATA_W-1:1]};
        end
        if (st.bit_cnt == `HCI_SER_CMD_BITS - 5'h01)
        begin
          next_st.req.addr = {1'b0, next_st.cmd[`HCI_DATA_W-1:1]};
          if (next_st.cmd[0])
          begin
            next_st.req.rd = 1'b1;
            next_st.load_pending = 1'b1;
          end
        end
        if (st.bit_cnt == `HCI_SER_FRAME_BITS - 5'h01 && !st.cmd[0])
        begin
          next_st.req.wdata = next_st.sdata;
          next_st.req.wr = 1'b1;
        end
      end
      // Launch skips the edge that closes the command byte
      if (launch_edge && st.cmd[0] && !st.load_pending && st.bit_cnt >= `HCI_SER_CMD_BITS)
      begin
        next_st.serial_out = st.sout[0];
        next_st.sout = {1'b0, st.sout[`HCI_DATA_W-1:1]};
        next_st.serial_oe = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '{
        sclk_q: 1'b0,
        par_phase: hci_pkg::HCI_PAR_IDLE,
        bit_cnt: '0,
        cmd: '0,
        sdata: '0,
        sout: '0,
        load_pending: 1'b0,
        serial_out: 1'b0,
        serial_oe: 1'b0,
        d_out: '0,
        d_oe: 1'b0,
        req: '0
      };
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign d_out = st.d_out;
  assign d_oe = st.d_oe;
  assign serial_out = st.serial_out;
  assign serial_oe = st.serial_oe;
  assign reg_rd = st.req.rd;
  assign reg_wr = st.req.wr;
  assign reg_addr = st.req.addr;
  assign reg_wdata = st.req.wdata;

endmodule : hci_top

// ---- common/hci_params.svh ----
`ifndef HCI_PARAMS_SVH
`define HCI_PARAMS_SVH

// ----------------------------------------
// Bus widths
// ----------------------------------------
`define HCI_ADDR_W 8
`define HCI_DATA_W 8

// ----------------------------------------
// Serial frame layout
// ----------------------------------------
`define HCI_SER_CMD_BITS 5'h08
`define HCI_SER_FRAME_BITS 5'h10
`define HCI_SER_CNT_W 5

// ----------------------------------------
// Synchroniser depth and pin count
// ----------------------------------------
`define HCI_SYNC_STAGES 2
`define HCI_PIN_W 23
// Idle pin levels: select, write strobe and data strobe high, shift clock low
`define HCI_PIN_RST 23'h580000

`endif

// ---- common/hci_pkg.sv ----
`include "hci_params.svh"

package hci_pkg;

  // ----------------------------------------
  // Parallel access phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    HCI_PAR_IDLE,
    HCI_PAR_WRITE,
    HCI_PAR_READ
  } hci_par_phase_t;

  // ----------------------------------------
  // Request toward the register bank
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`HCI_ADDR_W-1:0] addr;
    logic [`HCI_DATA_W-1:0] wdata;
  } hci_reg_req_t;

  // ----------------------------------------
  // Synchronised pin bundle
  // ----------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic serial_in;
    logic data_strobe_n;
    logic output_edge_select;
    logic bus_style_select;
    logic port_style_select;
    logic [`HCI_DATA_W-1:0] d_in;
    logic [`HCI_ADDR_W-1:0] addr;
  } hci_pins_t;

  // ----------------------------------------
  // Whole state of the port
  // ----------------------------------------
  typedef struct packed {
    logic sclk_q;
    hci_par_phase_t par_phase;
    logic [`HCI_SER_CNT_W-1:0] bit_cnt;
    logic [`HCI_DATA_W-1:0] cmd;
    logic [`HCI_DATA_W-1:0] sdata;
    logic [`HCI_DATA_W-1:0] sout;
    logic load_pending;
    logic serial_out;
    logic serial_oe;
    logic [`HCI_DATA_W-1:0] d_out;
    logic d_oe;
    hci_reg_req_t req;
  } hci_state_t;

endpackage : hci_pkg

// ---- hw/hci_sync.sv ----
module hci_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Stage one is read only by stage two
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Reset to the idle levels, so no false select or strobe follows reset
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule : hci_sync

// ---- sim/hci_top_properties.sv ----
// ----------------------------------------
// Port checker
// ----------------------------------------
module hci_top_checker (
  // Clock, reset, straps
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic port_style_select,
  input wire logic bus_style_select,
  input wire logic output_edge_select,
  // Pins and bank side
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic data_strobe_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] d_in,
  input wire logic [7:0] d_out,
  input wire logic d_oe,
  input wire logic serial_out,
  input wire logic serial_oe,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Five samples cover the two sync flops plus the output register
  sequence s_cs_idle;
    cs_n [*5];
  endsequence
  sequence s_par_wr;
    reg_wr && port_style_select;
  endsequence
  AST_IDLE_FLOAT: assert property (s_cs_idle |-> !d_oe && !serial_oe)
    else $error("bus driven while deselected");
  AST_SEL_REQ: assert property (reg_wr || reg_rd |-> !$past(cs_n, 2))
    else $error("request without select");
  AST_PAR_OE: assert property (d_oe |-> port_style_select)
    else $error("data bus driven in serial mode");
  AST_SER_OE: assert property (serial_oe |-> !port_style_select)
    else $error("serial out driven in parallel mode");
  AST_DIR_WR: assert property (s_par_wr ##0 !bus_style_select |-> !$past(serial_in, 2))
    else $error("write with read direction");
  AST_DIR_RD: assert property (reg_rd && port_style_select && !bus_style_select
    |-> $past(serial_in, 2))
    else $error("read with write direction");
  AST_SEP_RD: assert property (reg_rd && port_style_select && bus_style_select
    |-> !$past(data_strobe_n, 2) && $past(serial_in, 2))
    else $error("read without read strobe");
  AST_RD_DATA: assert property (d_oe |-> d_out == $past(reg_rd_data))
    else $error("read data not from bank");
  AST_WR_DATA: assert property (s_par_wr |->
    reg_wdata == $past(d_in, 2) && reg_addr == $past(addr, 2))
    else $error("write data or address wrong");
  AST_SER_EDGE: assert property (serial_oe && $changed(serial_out)
    |-> sclk != output_edge_select)
    else $error("serial out launched on wrong edge");
endmodule : hci_top_checker

bind hci_top hci_top_checker i_chk (.*);

// ---- sim/hci_host_model.sv ----
// ----------------------------------------
// Host side of the control port
// ----------------------------------------
module hci_host_model (
  // Clock and straps
  input wire logic clk,
  input wire logic port_style_select,
  input wire logic bus_style_select,
  input wire logic output_edge_select,
  // Pins
  output logic cs_n,
  output logic sclk,
  output logic serial_in,
  output logic data_strobe_n,
  output logic [7:0] addr,
  output logic [7:0] hd,
  input wire logic [7:0] d_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {cs_n, data_strobe_n, serial_in, sclk} = 4'hE;
    addr = 8'h00;
    hd = 8'h00;
  end
  // Shift clock stands low outside frames
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d,
    input logic sel, output logic [7:0] q);
    logic [15:0] f;
    f = {d, a[6:0], rd};
    q = 8'h00;
    @(negedge clk);
    cs_n = !sel;
    addr = a;
    hd = rd ? ~hd : d;
    serial_in = port_style_select && !bus_style_select ? rd : 1'h1;
    repeat (2) @(negedge clk);
    if (port_style_select)
    begin
      if (rd || !bus_style_select)
        data_strobe_n = 1'h0;
      else
        serial_in = 1'h0;
      repeat (8) @(negedge clk);
      q = d_in;
      data_strobe_n = 1'h1;
      if (bus_style_select)
        serial_in = 1'h1;
    end
    else
    begin
      // Offset keeps shift-clock edges off the system clock edges
      #1;
      for (int i = 0; i < 16; i++)
      begin
        serial_in = f[i];
        #62.5;
        if (output_edge_select && i > 7)
          q[i-8] = serial_out;
        sclk = 1'h1;
        #62.5;
        if (!output_edge_select && i > 7)
          q[i-8] = serial_out;
        sclk = 1'h0;
      end
    end
    repeat (5) @(negedge clk);
    cs_n = 1'h1;
    repeat (4) @(negedge clk);
  endtask : access
endmodule : hci_host_model

// ---- sim/host_control_interface_tb_top.sv ----
// ----------------------------------------
// Bench top
// ----------------------------------------
module host_control_interface_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, port_style_select, bus_style_select, output_edge_select;
  logic cs_n, sclk, serial_in, data_strobe_n, d_oe, serial_out, serial_oe, reg_rd, reg_wr;
  logic [7:0] addr, hd, d_in, d_out, reg_addr, reg_wdata, reg_rd_data, q, a, d;
  logic [7:0] mem [256] = '{default: 8'h00};
  int ref_mem [256] = '{default: 0};
  logic [15:0] wq [$];
  logic serial_line;
  int n_errors = 0;
  int check_count = 0;
  assign d_in = d_oe ? d_out : hd;
  assign reg_rd_data = mem[reg_addr];
  hci_top i_dut (.*);
  // Released line shows the inverse, so a missing enable is caught
  assign serial_line = serial_oe ? serial_out : ~serial_out;
  hci_host_model i_host (.*, .serial_out(serial_line));
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Bank model; a spurious write finds the queue empty
  always @(posedge clk)
    if (reg_wr === 1'h1)
    begin
      mem[reg_addr] <= reg_wdata;
      chk("write", wq.size() ? wq.pop_front() : 16'hXXXX, {reg_addr, reg_wdata});
    end
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200us;
    n_errors++;
    stop_test();
  end
  initial
  begin
    {port_style_select, bus_style_select, output_edge_select} = 3'h0;
    sys_rst = 1'h1;
    void'($urandom(77));
    repeat (10) @(posedge clk);
    @(negedge clk) sys_rst = 1'h0;
    // Serial both edges, then both parallel styles
    for (int m = 0; m < 4; m++)
    begin
      {port_style_select, bus_style_select, output_edge_select} = {m[1], m[0], m[0]};
      repeat (4) @(negedge clk);
      for (int k = 0; k < 6; k++)
      begin
        a = 8'($urandom);
        d = 8'($urandom);
        a[7] = a[7] & m[1];
        if (k != 2)
        begin
          ref_mem[a] = d;
          wq.push_back({a, d});
        end
        i_host.access(1'h0, a, d, k != 2, q);
        i_host.access(1'h1, a, 8'h00, 1'h1, q);
        chk("read", ref_mem[a], q);
      end
    end
    chk("pending", 0, wq.size());
    stop_test();
  end
endmodule : host_control_interface_tb_top
